// file: verilog/power_mode_pkg.sv
package power_mode_pkg;

  // ----------------------------------------------------------------
  // power control register layout
  // ----------------------------------------------------------------
  localparam int          IDLE_BIT_POS      = 0;
  localparam int          PDOWN_BIT_POS     = 1;
  localparam int          FLAG_A_POS        = 2;
  localparam int          FLAG_B_POS        = 3;
  localparam logic [7:0]  PCTRL_RESET       = 8'h00;
  localparam logic [7:0]  PCTRL_ADDR        = 8'h00;
  localparam logic [7:0]  PCTRL_WMASK       = 8'h0F;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_PS     = 5000;
  localparam int          MACHINE_CYC_CLK   = 12;
  localparam int          WDOG_RESTART_MC   = 3;
  localparam int          WDOG_RESTART_CLK  = WDOG_RESTART_MC * MACHINE_CYC_CLK;
  localparam int          HF_RESET_PERIODS  = 24;
  localparam int          PLL_RST_MIN_NS    = 1000;
  localparam int          PLL_RST_MIN_CLK   = (PLL_RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
  localparam int          PLL_RESTART_US    = 63000;
  localparam int          PLL_RESTART_CLK   = PLL_RESTART_US / 5 * 1000;
  localparam logic [7:0]  NUM_WAKE_SRC      = 8'h07;

  // ----------------------------------------------------------------
  // wake sources: 0 ext a, 1 timer0, 2 ext b, 3 seconds,
  // 4 timer1, 5 async serial, 6 two-wire serial
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_IDLE  = 2'b01,
    ST_PDOWN = 2'b11,
    ST_RSTRT = 2'b10
  } mode_type;

  typedef struct packed {
    logic [6:0] req;
    logic [6:0] enable;
    logic [6:0] high_prio;
    logic       in_service_low;
    logic       in_service_high;
  } irq_view_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

endpackage

// file: verilog/reduced_power_mode_control.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: idle write is last instruction; CPU halts, state kept
// R2: idle stops timer two, pulses high, conversion aborted
// R3: idle keeps interrupts, timers, serials, watchdog running
// R4: enabled irq clears idle unless equal priority serving; code also holds idle while a higher level is serving
// R5: after handler, resume after idle-setting instruction
// R6: external party holds HF reset 24 periods
// R7: PLL reset 1us..10ms; restart about 63ms later
// R8: watchdog reset ends idle; restart three machine cycles
// R9: power-down halts clock, HF osc; slow osc optional
// R10: power-down and irq wake keep RAM and registers
// R11: power-down refused while watchdog enabled
// R12: external reset ends power-down, clears registers
// R13: external fetch power-down restores port two latch
// R14: software avoids power-down inside interrupt handler
// R15: busy priority turns power-down wake into idle
// R16: external wake pin level mode, held low
// R17: seconds wake needs enable and ext b level mode
// R18: software gives wake source highest priority
// R19: after wake handler, resume after power-down instruction
// R20: address strobe, fetch strobe, pulse outputs per mode
// R21: two-wire pins live in idle only when enabled
// R22: user flags freely writable, also by idle write
// R23: idle bit 0, power-down bit 1, needs watchdog input
// R24: wake by irq clears the active select bit
module reduced_power_mode_control (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  // register port
  input  wire power_mode_pkg::reg_req_type   reg_req_i,
  output logic [7:0]                         reg_rdata_o,
  // interrupt view
  input  wire power_mode_pkg::irq_view_type  irq_i,
  input  wire logic                          ext_irq_a_level_i,
  input  wire logic                          ext_irq_b_level_i,
  // system status
  input  wire logic                          watchdog_enable_input_i,
  input  wire logic                          watchdog_reset_i,
  input  wire logic                          osc_source_select_i,
  input  wire logic                          slow_osc_keep_alive_i,
  input  wire logic                          ext_fetch_i,
  input  wire logic                          two_wire_serial_enable_i,
  // controls
  output logic                               cpu_halt_o,
  output logic                               sys_clk_run_o,
  output logic                               hf_osc_run_o,
  output logic                               slow_osc_run_o,
  output logic                               timer_two_reset_o,
  output logic                               conv_abort_o,
  output logic                               pulse_out_a_o,
  output logic                               pulse_out_b_o,
  output logic                               addr_strobe_o,
  output logic                               program_fetch_strobe_o,
  output logic                               port_two_restore_o,
  output logic                               two_wire_pins_oe_o,
  output logic                               wake_restart_o,
  output logic [1:0]                         mode_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  power_mode_pkg::mode_type mode_r;
  power_mode_pkg::mode_type mode_nxt;
  logic [7:0]  power_control_reg_r;
  logic [7:0]  power_control_reg_nxt;
  logic [5:0]  restart_cnt_r;
  logic [6:0]  live_src;
  logic        idle_wake;
  logic        pd_wake;
  logic        pd_wake_busy;
  logic        pd_write;
  logic        idle_write;
  logic        pd_refused;

  // ----------------------------------------------------------------
  // wake decisions
  // ----------------------------------------------------------------
  assign live_src = irq_i.req & irq_i.enable;

  // a source wakes idle unless same or higher level is already serving
  always_comb begin
    idle_wake = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (live_src[i] && !irq_i.in_service_high
          && !(irq_i.in_service_low && !irq_i.high_prio[i])) begin
        idle_wake = 1'b1; // R4
      end
    end
  end

  // power-down wake: ext a/b only level-sensitive; seconds needs ext b level
  always_comb begin
    pd_wake = (live_src[0] && ext_irq_a_level_i)
            || (live_src[2] && ext_irq_b_level_i)
            || (live_src[3] && ext_irq_b_level_i); // R17
    pd_wake_busy = 1'b0;
    if (live_src[0] && ext_irq_a_level_i && (irq_i.in_service_high
        || (irq_i.in_service_low && !irq_i.high_prio[0]))) begin
      pd_wake_busy = 1'b1; // R15
    end
    if (((live_src[2] || live_src[3]) && ext_irq_b_level_i) && (irq_i.in_service_high
        || (irq_i.in_service_low && !irq_i.high_prio[2]))) begin
      pd_wake_busy = 1'b1; // R15
    end
  end

  assign idle_write = reg_req_i.wr && (reg_req_i.addr == power_mode_pkg::PCTRL_ADDR)
                      && reg_req_i.wdata[power_mode_pkg::IDLE_BIT_POS];
  assign pd_write   = reg_req_i.wr && (reg_req_i.addr == power_mode_pkg::PCTRL_ADDR)
                      && reg_req_i.wdata[power_mode_pkg::PDOWN_BIT_POS];
  // watchdog enabled means the input is low; power-down bit then stays clear
  assign pd_refused = pd_write && !watchdog_enable_input_i; // R11

  // ----------------------------------------------------------------
  // power control register
  // ----------------------------------------------------------------
  always_comb begin
    power_control_reg_nxt = power_control_reg_r;
    if (reg_req_i.wr && reg_req_i.addr == power_mode_pkg::PCTRL_ADDR) begin
      // flags written alongside the idle bit in the same instruction
      power_control_reg_nxt = reg_req_i.wdata & power_mode_pkg::PCTRL_WMASK; // R22
      power_control_reg_nxt[power_mode_pkg::PDOWN_BIT_POS] =
        reg_req_i.wdata[power_mode_pkg::PDOWN_BIT_POS] && watchdog_enable_input_i; // R23
    end
    if (mode_r == power_mode_pkg::ST_IDLE && idle_wake) begin
      power_control_reg_nxt[power_mode_pkg::IDLE_BIT_POS] = 1'b0; // R24
    end
    if (mode_r == power_mode_pkg::ST_PDOWN && pd_wake) begin
      power_control_reg_nxt[power_mode_pkg::PDOWN_BIT_POS] = 1'b0; // R24
      power_control_reg_nxt[power_mode_pkg::IDLE_BIT_POS]  = pd_wake_busy; // R15
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || watchdog_reset_i) begin
      power_control_reg_r <= power_mode_pkg::PCTRL_RESET; // R12
    end else begin
      power_control_reg_r <= power_control_reg_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd && reg_req_i.addr == power_mode_pkg::PCTRL_ADDR) begin
      reg_rdata_o <= power_control_reg_r;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      power_mode_pkg::ST_RUN: begin
        // write is the last instruction; halt starts next cycle
        if (pd_write && !pd_refused) begin
          mode_nxt = power_mode_pkg::ST_PDOWN; // R9
        end else if (idle_write) begin
          mode_nxt = power_mode_pkg::ST_IDLE; // R1
        end
      end
      power_mode_pkg::ST_IDLE: begin
        if (idle_wake) begin
          mode_nxt = power_mode_pkg::ST_RUN; // R5
        end
      end
      power_mode_pkg::ST_PDOWN: begin
        if (pd_wake) begin
          mode_nxt = pd_wake_busy ? power_mode_pkg::ST_IDLE
                                  : power_mode_pkg::ST_RUN; // R19
        end
      end
      power_mode_pkg::ST_RSTRT: begin
        if (restart_cnt_r == 6'd1) begin
          mode_nxt = power_mode_pkg::ST_RUN; // R8
        end
      end
    endcase
    // outputs follow mode_nxt, so the restart must show from its first cycle
    if (watchdog_reset_i) begin
      mode_nxt = power_mode_pkg::ST_RSTRT; // R8
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_r <= power_mode_pkg::ST_RUN; // R12 R7
    end else if (watchdog_reset_i) begin
      mode_r <= power_mode_pkg::ST_RSTRT; // R8
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      restart_cnt_r <= 6'd0;
    end else if (watchdog_reset_i) begin
      restart_cnt_r <= 6'(power_mode_pkg::WDOG_RESTART_CLK); // R8
    end else if (restart_cnt_r != 6'd0) begin
      restart_cnt_r <= restart_cnt_r - 6'd1;
    end
  end

  // ----------------------------------------------------------------
  // outputs per mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cpu_halt_o             <= 1'b0;
      sys_clk_run_o          <= 1'b1;
      hf_osc_run_o           <= 1'b1;
      slow_osc_run_o         <= 1'b0;
      timer_two_reset_o      <= 1'b0;
      conv_abort_o           <= 1'b0;
      pulse_out_a_o          <= 1'b1;
      pulse_out_b_o          <= 1'b1;
      addr_strobe_o          <= 1'b1;
      program_fetch_strobe_o <= 1'b1;
      port_two_restore_o     <= 1'b0;
      two_wire_pins_oe_o     <= 1'b0;
      wake_restart_o         <= 1'b0;
      mode_o                 <= 2'b00;
    end else begin
      // registers and RAM are untouched in all low-power modes
      cpu_halt_o        <= (mode_nxt != power_mode_pkg::ST_RUN); // R1 R10
      sys_clk_run_o     <= (mode_nxt != power_mode_pkg::ST_PDOWN); // R9
      hf_osc_run_o      <= !(mode_nxt == power_mode_pkg::ST_PDOWN)
                           && osc_source_select_i; // R9
      slow_osc_run_o    <= !osc_source_select_i && ((mode_nxt != power_mode_pkg::ST_PDOWN)
                           || slow_osc_keep_alive_i); // R9
      timer_two_reset_o <= (mode_nxt == power_mode_pkg::ST_IDLE); // R2
      conv_abort_o      <= (mode_nxt == power_mode_pkg::ST_IDLE); // R2
      pulse_out_a_o     <= 1'b1; // R20
      pulse_out_b_o     <= 1'b1; // R20
      addr_strobe_o     <= (mode_nxt != power_mode_pkg::ST_PDOWN); // R20
      program_fetch_strobe_o <= (mode_nxt != power_mode_pkg::ST_PDOWN); // R20
      port_two_restore_o <= (mode_nxt == power_mode_pkg::ST_PDOWN) && ext_fetch_i; // R13
      two_wire_pins_oe_o <= (mode_nxt != power_mode_pkg::ST_PDOWN)
                            && two_wire_serial_enable_i; // R21
      wake_restart_o    <= (mode_r != power_mode_pkg::ST_RUN)
                           && (mode_nxt == power_mode_pkg::ST_RUN); // R5 R19
      mode_o            <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_pd_refused: assert property (@(posedge clk_i) disable iff (reset_i) // R11
    (mode_r == power_mode_pkg::ST_RUN && pd_write && !watchdog_enable_input_i
     && !watchdog_reset_i) |=> (mode_r != power_mode_pkg::ST_PDOWN))
    else $error("power-down entered with watchdog enabled");

  chk_idle_entry: assert property (@(posedge clk_i) disable iff (reset_i) // R1
    (mode_r == power_mode_pkg::ST_RUN && idle_write && !pd_write && !watchdog_reset_i)
    |=> (mode_r == power_mode_pkg::ST_IDLE) && cpu_halt_o)
    else $error("idle not entered after idle write");

  chk_idle_wake: assert property (@(posedge clk_i) disable iff (reset_i) // R4
    (mode_r == power_mode_pkg::ST_IDLE && idle_wake && !watchdog_reset_i)
    |=> mode_r == power_mode_pkg::ST_RUN
        && !power_control_reg_r[power_mode_pkg::IDLE_BIT_POS])
    else $error("idle wake did not clear idle bit");

  chk_idle_block: assert property (@(posedge clk_i) disable iff (reset_i) // R4
    (mode_r == power_mode_pkg::ST_IDLE && irq_i.in_service_high && !watchdog_reset_i)
    |=> mode_r == power_mode_pkg::ST_IDLE)
    else $error("idle left while high level in service");

  chk_pd_to_idle: assert property (@(posedge clk_i) disable iff (reset_i) // R15
    (mode_r == power_mode_pkg::ST_PDOWN && pd_wake && pd_wake_busy && !watchdog_reset_i)
    |=> mode_r == power_mode_pkg::ST_IDLE)
    else $error("busy wake did not fall into idle");

  chk_wdog_load: assert property (@(posedge clk_i) disable iff (reset_i) // R8
    watchdog_reset_i |=> mode_r == power_mode_pkg::ST_RSTRT
      && restart_cnt_r == 6'(power_mode_pkg::WDOG_RESTART_CLK))
    else $error("watchdog restart count not loaded");

  chk_wdog_restart: assert property (@(posedge clk_i) disable iff (reset_i) // R8
    (mode_r == power_mode_pkg::ST_RSTRT && restart_cnt_r == 6'd1 && !watchdog_reset_i)
    |=> mode_r == power_mode_pkg::ST_RUN)
    else $error("watchdog restart not three machine cycles");

  chk_pd_strobes: assert property (@(posedge clk_i) disable iff (reset_i) // R20
    (mode_o == 2'b11) |-> !addr_strobe_o && !program_fetch_strobe_o && pulse_out_a_o)
    else $error("power-down strobe levels wrong");

  chk_two_wire: assert property (@(posedge clk_i) disable iff (reset_i) // R21
    (mode_o == 2'b11) |-> !two_wire_pins_oe_o)
    else $error("two-wire pins driven in power-down");

  chk_sec_wake: assert property (@(posedge clk_i) disable iff (reset_i) // R17
    (mode_r == power_mode_pkg::ST_PDOWN && !ext_irq_b_level_i && !live_src[0])
    |=> mode_r != power_mode_pkg::ST_RUN)
    else $error("wake without level mode");

endmodule

`default_nettype wire

// file: test/irq_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// far side: interrupt lines, enables and priorities
// ----------------------------------------------------------------
module irq_source_model (
  // clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           reset_i,
  // scenario control
  input  wire logic [6:0]                     fire_i,
  input  wire logic [6:0]                     enable_i,
  input  wire logic [6:0]                     high_prio_i,
  input  wire logic [1:0]                     busy_i,
  // device view
  input  wire logic                           cpu_halt_i,
  output var  power_mode_pkg::irq_view_type   irq_o
);
  logic [6:0] req_r;

  // a wake request stays set until the core runs again, else the wake is lost
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      req_r <= 7'h00;
    end else if (fire_i != 7'h00) begin
      req_r <= req_r | fire_i;
    end else if (!cpu_halt_i) begin
      req_r <= 7'h00;
    end
  end

  // wake source priority set by the scenario
  assign irq_o = {req_r, enable_i, high_prio_i, busy_i[0], busy_i[1]};
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                          clk_i;
  logic                          reset_i;
  power_mode_pkg::reg_req_type   reg_req_i;
  power_mode_pkg::irq_view_type  irq_i;
  logic                          a_lvl, b_lvl, wd_en, wd_rst, osc_sel, keep32, fetch, tw_en;
  logic [6:0]                    fire, enable, prio;
  logic [1:0]                    busy, mode;
  logic [7:0]                    rdata;
  logic                          halt, clk_run, hf_run, slow_run, t2_rst, abort, pa, pb;
  logic                          ale, program_fetch_strobe, p2_rst, tw_oe, restart;
  int                            mismatches, n_compared, n;
  bit                            saw_restart;

  reduced_power_mode_control i_reduced_power_mode_control (
    .clk_i(clk_i), .reset_i(reset_i), .reg_req_i(reg_req_i), .reg_rdata_o(rdata),
    .irq_i(irq_i), .ext_irq_a_level_i(a_lvl), .ext_irq_b_level_i(b_lvl),
    .watchdog_enable_input_i(wd_en), .watchdog_reset_i(wd_rst),
    .osc_source_select_i(osc_sel), .slow_osc_keep_alive_i(keep32), .ext_fetch_i(fetch),
    .two_wire_serial_enable_i(tw_en), .cpu_halt_o(halt), .sys_clk_run_o(clk_run),
    .hf_osc_run_o(hf_run), .slow_osc_run_o(slow_run), .timer_two_reset_o(t2_rst),
    .conv_abort_o(abort), .pulse_out_a_o(pa), .pulse_out_b_o(pb), .addr_strobe_o(ale),
    .program_fetch_strobe_o(program_fetch_strobe), .port_two_restore_o(p2_rst), .two_wire_pins_oe_o(tw_oe),
    .wake_restart_o(restart), .mode_o(mode));

  irq_source_model i_irq_source_model (
    .clk_i(clk_i), .reset_i(reset_i), .fire_i(fire), .enable_i(enable), .high_prio_i(prio),
    .busy_i(busy), .cpu_halt_i(halt), .irq_o(irq_i));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) reg_req_i <= {1'b1, 1'b0, a, d};
    @(posedge clk_i) reg_req_i <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i) reg_req_i <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i) reg_req_i <= '0;
    #1 chk(rdata, exp);
  endtask

  // one-cycle request burst from the far side
  task automatic raise(input logic [6:0] src);
    @(posedge clk_i) fire <= src;
    @(posedge clk_i) fire <= 7'h00;
  endtask

  task automatic wait_mode(input logic [1:0] exp);
    #1 saw_restart = (restart === 1'b1);
    for (int i = 0; i < 30 && mode !== exp; i++) begin
      @(posedge clk_i);
      #1 saw_restart = saw_restart | (restart === 1'b1);
    end
    chk({6'h00, mode}, {6'h00, exp});
  endtask

  // halt, clock, hf, slow, ale, fetch strobe, pulse a, pulse b
  task automatic pins(input logic [7:0] exp);
    #1 chk({halt, clk_run, hf_run, slow_run, ale, program_fetch_strobe, pa, pb}, exp);
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    pins(8'h6F);
    rd(8'h00, 8'h00);
    rd(8'h55, 8'h00);
  endtask

  // flags ride along with the idle write
  task automatic t_idle;
    wr(8'h00, 8'h0D);
    @(posedge clk_i);
    pins(8'hEF);
    chk({5'h00, t2_rst, abort, tw_oe}, 8'h07);
    rd(8'h00, 8'h0D);
    raise(7'h02);
    wait_mode(power_mode_pkg::ST_RUN);
    chk({7'h00, saw_restart}, 8'h01);
    rd(8'h00, 8'h0C);
  endtask

  task automatic t_idle_blocked;
    @(posedge clk_i) busy <= 2'b10;
    wr(8'h00, 8'h01);
    raise(7'h10);
    repeat (6) @(posedge clk_i);
    #1 chk({6'h00, mode}, {6'h00, power_mode_pkg::ST_IDLE});
    @(posedge clk_i) busy <= 2'b01;
    repeat (6) @(posedge clk_i);
    #1 chk({6'h00, mode}, {6'h00, power_mode_pkg::ST_IDLE});
    @(posedge clk_i) prio <= 7'h7F;
    wait_mode(power_mode_pkg::ST_RUN);
    @(posedge clk_i) busy <= 2'b00;
    prio <= 7'h00;
  endtask

  task automatic t_pd_refused;
    @(posedge clk_i) wd_en <= 1'b0;
    wr(8'h00, 8'h02);
    @(posedge clk_i);
    #1 chk({6'h00, mode}, {6'h00, power_mode_pkg::ST_RUN});
    rd(8'h00, 8'h00);
  endtask

  task automatic t_pd_ext;
    @(posedge clk_i) wd_en <= 1'b1;
    osc_sel <= 1'b0;
    keep32 <= 1'b1;
    fetch <= 1'b1;
    a_lvl <= 1'b1;
    wr(8'h00, 8'h02);
    @(posedge clk_i);
    pins(8'h93);
    chk({6'h00, p2_rst, tw_oe}, 8'h02);
    rd(8'h00, 8'h02);
    raise(7'h01);
    wait_mode(power_mode_pkg::ST_RUN);
    rd(8'h00, 8'h00);
  endtask

  task automatic t_pd_seconds;
    @(posedge clk_i) osc_sel <= 1'b1;
    b_lvl <= 1'b0;
    wr(8'h00, 8'h02);
    raise(7'h08);
    repeat (6) @(posedge clk_i);
    pins(8'h83);
    @(posedge clk_i) b_lvl <= 1'b1;
    wait_mode(power_mode_pkg::ST_RUN);
  endtask

  task automatic t_pd_busy;
    @(posedge clk_i) busy <= 2'b10;
    wr(8'h00, 8'h02);
    raise(7'h01);
    wait_mode(power_mode_pkg::ST_IDLE);
    rd(8'h00, 8'h01);
    @(posedge clk_i) busy <= 2'b00;
    wait_mode(power_mode_pkg::ST_RUN);
  endtask

  task automatic t_ext_reset;
    wr(8'h00, 8'h01);
    @(posedge clk_i) reset_i <= 1'b1;
    repeat (power_mode_pkg::HF_RESET_PERIODS) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1 chk({6'h00, mode}, {6'h00, power_mode_pkg::ST_RUN});
    rd(8'h00, 8'h00);
  endtask

  task automatic t_watchdog;
    wr(8'h00, 8'h05);
    @(posedge clk_i) wd_rst <= 1'b1;
    @(posedge clk_i) wd_rst <= 1'b0;
    #1 n = 0;
    while (mode === power_mode_pkg::ST_RSTRT && n < 100) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk(8'(n), 8'(power_mode_pkg::WDOG_RESTART_CLK));
    rd(8'h00, 8'h00);
  endtask

  initial begin
    #20000;
    mismatches++;
    final_report;
  end

  initial begin
    reset_i = 1'b1;
    reg_req_i = '0;
    {a_lvl, b_lvl, wd_en, wd_rst, osc_sel, keep32, fetch, tw_en} = 8'hA9;
    {fire, enable, prio, busy} = {7'h00, 7'h7F, 7'h00, 2'b00};
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset;
    t_idle;
    t_idle_blocked;
    t_pd_refused;
    t_pd_ext;
    t_pd_seconds;
    t_pd_busy;
    t_ext_reset;
    t_watchdog;
    final_report;
  end
endmodule
`default_nettype wire
